// ### hdl/btsc_pkg.sv
package btsc_pkg;
    // ------------------------------------------------------------
    // instruction word layout
    // ------------------------------------------------------------
    localparam int          INSTR_W        = 12;       // program word width
    localparam int          DATA_W         = 8;        // file register width
    localparam int          ADDR_W         = 5;        // file address width
    localparam int          BSEL_W         = 3;        // bit selector width
    localparam logic [3:0]  OPC_BIT_SKIP   = 4'h7;     // top nibble 0111
    localparam logic [5:0]  OPC_COMPLEMENT = 6'h09;    // top six bits 0010 01
    localparam int          OPC4_MSB       = 11;       // top nibble position
    localparam int          OPC4_LSB       = 8;
    localparam int          OPC6_LSB       = 6;        // six-bit opcode low bit
    localparam int          BSEL_LSB       = 5;        // bit selector low bit
    localparam int          DEST_POS       = 5;        // destination bit
    localparam int          ADDR_LSB       = 0;        // file address low bit
    localparam logic        DEST_WREG      = 1'b0;     // result to working register
    localparam logic [DATA_W-1:0] W_RESET  = 8'h00;    // working register at reset
    localparam logic        ZERO_RESET     = 1'b0;     // zero flag at reset
    localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;  // write address at reset
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;  // write data at reset
endpackage : btsc_pkg

// ### hdl/btsc_skip_slot.sv
// ------------------------------------------------------------
// one-deep slot remembering that the next fetched word is void
// ------------------------------------------------------------
module btsc_skip_slot (
    input  wire logic clk_i,     // core clock
    input  wire logic rst_i,     // synchronous reset, high
    input  wire logic set_i,     // skip taken this cycle
    input  wire logic adv_i,     // pipeline advances
    output logic      void_o     // word now executing is discarded
);
    logic void_q;                // registered slot

    // slot arms on a taken skip, drains on the next advance
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            void_q <= 1'b0;
        end else if (adv_i) begin
            void_q <= set_i;
        end
    end

    assign void_o = void_q;
endmodule : btsc_skip_slot

// ### hdl/btsc_exec.sv
// Summary of operation
// RULE1: decode 0111 bbb fffff, skip when bit set
// RULE2: taken skip voids next word, two cycles
// RULE3: decode 0010 01 d fffff, invert file register
// RULE4: d=0 writes working register, d=1 file
// RULE5: complement sets zero flag; bit test keeps flags
module btsc_exec
    import btsc_pkg::*;
(
    input  wire logic                          CLK_I,        // core clock, 125 MHz
    input  wire logic                          RST_I,        // synchronous reset, high
    input  wire logic                          VALID_I,      // fetched word valid, pipeline advances
    input  wire logic [btsc_pkg::INSTR_W-1:0]  INSTR_I,      // fetched instruction word
    input  wire logic [btsc_pkg::DATA_W-1:0]   FILE_RDATA_I, // read data of addressed file register
    output logic      [btsc_pkg::ADDR_W-1:0]   FILE_RADDR_O, // file read address (registered)
    output logic                               FILE_WE_O,    // file write strobe, one cycle
    output logic      [btsc_pkg::ADDR_W-1:0]   FILE_WADDR_O, // file write address
    output logic      [btsc_pkg::DATA_W-1:0]   FILE_WDATA_O, // file write data
    output logic      [btsc_pkg::DATA_W-1:0]   WREG_O,       // working register
    output logic                               ZERO_O,       // zero flag
    output logic                               SKIP_O,       // skip taken, pulse
    output logic                               NOP_O         // voided word executing, pulse
);
    import btsc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // the pipeline state in one word, registered once; only the discard slot sits outside it
    typedef struct packed {
        logic [ADDR_W-1:0] raddr;    // address of word in execute
        logic [BSEL_W-1:0] bsel;     // bit selector held for execute
        logic              is_skip;  // execute holds a bit test
        logic              is_comp;  // execute holds a complement
        logic              dest;     // destination of complement
        logic              we;       // file write strobe
        logic [ADDR_W-1:0] waddr;    // file write address
        logic [DATA_W-1:0] wdata;    // file write data
        logic [DATA_W-1:0] wreg;     // working register
        logic              zero;     // zero flag
        logic              skip;     // skip pulse
        logic              no_operation;      // discarded word pulse
    } btsc_state_t;

    // ------------------------------------------------------------
    // internal signals
    // ------------------------------------------------------------
    // bit_hit, inv and skip_take below are set at the top of the comb process; void_now comes from the slot
    btsc_state_t       s_q;          // registered state
    btsc_state_t       s_d;          // next state
    logic              void_now;     // current execute word is discarded
    logic              bit_hit;      // tested bit is one
    logic [DATA_W-1:0] inv;          // complemented operand
    logic              skip_take;    // skip decided this cycle

    // ------------------------------------------------------------
    // discard slot
    // ------------------------------------------------------------
    // slot only moves with the pipeline, so a stall keeps a pending discard;
    // it is the only state kept outside the struct
    btsc_skip_slot u_slot (
        .clk_i  (CLK_I),
        .rst_i  (RST_I),
        .set_i  (skip_take),
        .adv_i  (VALID_I),
        .void_o (void_now)
    );

    // ------------------------------------------------------------
    // decode and execute
    // ------------------------------------------------------------
    // file operand arrives in the cycle after decode, while the registered address is out,
    // so decode fields are latched alongside the read address
    always_comb begin
        s_d       = s_q;
        s_d.we    = 1'b0;
        s_d.skip  = 1'b0;
        s_d.no_operation   = 1'b0;
        bit_hit   = FILE_RDATA_I[s_q.bsel];                             // RULE1
        inv       = ~FILE_RDATA_I;                                      // RULE3
        skip_take = VALID_I && s_q.is_skip && !void_now && bit_hit;     // RULE1
        if (VALID_I) begin
            // execute stage: word latched last cycle
            if (void_now) begin
                // word fetched behind a taken skip: run as a no_operation
                s_d.no_operation = 1'b1;                                         // RULE2
            end else if (s_q.is_skip) begin
                // flags and registers untouched, only the skip pulse
                s_d.skip = bit_hit;                                     // RULE1 RULE5
            end else if (s_q.is_comp) begin
                // zero flag follows the inverted value, both destinations
                s_d.zero = (inv == DATA_RESET);                         // RULE5
                if (s_q.dest == DEST_WREG) begin
                    // result kept in the working register
                    s_d.wreg = inv;                                     // RULE4
                end else begin
                    // result written back to the addressed file register
                    s_d.we    = 1'b1;                                   // RULE4
                    s_d.waddr = s_q.raddr;
                    s_d.wdata = inv;
                end
            end
            // any other opcode falls through with no effect
            // decode stage: latch fields of the new word
            s_d.raddr   = INSTR_I[ADDR_LSB +: ADDR_W];
            s_d.bsel    = INSTR_I[BSEL_LSB +: BSEL_W];
            s_d.dest    = INSTR_I[DEST_POS];
            s_d.is_skip = (INSTR_I[OPC4_MSB:OPC4_LSB] == OPC_BIT_SKIP);     // RULE1
            s_d.is_comp = (INSTR_I[OPC4_MSB:OPC6_LSB] == OPC_COMPLEMENT);   // RULE3
        end
        // valid low: everything holds; the pulses above already
        // dropped, so a stall never repeats a write
    end

    // registered state; hazard: a bit test right after a file write
    // of the same register sees old data, the core must forward
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            // every field named, so a new field cannot slip past reset
            s_q <= '{raddr:   ADDR_RESET,   // no address in flight
                     bsel:    '0,
                     is_skip: 1'b0,         // empty execute stage
                     is_comp: 1'b0,
                     dest:    1'b0,
                     we:      1'b0,         // no stray write on release
                     waddr:   ADDR_RESET,
                     wdata:   DATA_RESET,
                     wreg:    W_RESET,
                     zero:    ZERO_RESET,
                     skip:    1'b0,
                     no_operation:     1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every port is a field of the state register, no logic after it
    assign FILE_RADDR_O = s_q.raddr;
    assign FILE_WE_O    = s_q.we;
    assign FILE_WADDR_O = s_q.waddr;
    assign FILE_WDATA_O = s_q.wdata;
    // held values
    assign WREG_O       = s_q.wreg;
    assign ZERO_O       = s_q.zero;
    // one-cycle pulses
    assign SKIP_O       = s_q.skip;
    assign NOP_O        = s_q.no_operation;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // internal nets are used where the ports alone cannot tell
    // a discarded word from an idle one; a stall may sit between
    // any two executed words, so each check of an executed word starts on a valid edge
    // a taken skip arms the discard slot for the very next word
    chk_skip_voids_next: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE2
        skip_take |=> void_now)
        else $error("taken skip did not arm the discard");
    // the discarded word shows only as a no_operation pulse
    chk_void_gives_nop: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE2
        (VALID_I && void_now) |=> (NOP_O && !SKIP_O && !FILE_WE_O))
        else $error("discarded word not run as no_operation");
    // an untaken skip takes one cycle and voids nothing
    chk_untaken_single: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE2
        (VALID_I && s_q.is_skip && !void_now && !bit_hit) |=> !void_now)
        else $error("untaken skip discarded a word");
    // skip pulse mirrors the tested bit of the operand
    chk_skip_on_bit: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE1
        (VALID_I && s_q.is_skip && !void_now) |=> (SKIP_O == $past(bit_hit)))
        else $error("skip does not follow tested bit");
    // file address goes out one cycle after decode
    chk_raddr_decode: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE1
        VALID_I |=> (FILE_RADDR_O == $past(INSTR_I[ADDR_LSB +: ADDR_W])))
        else $error("file address not taken from word");
    // complement to file: strobe and inverted data
    chk_comp_file_write: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE3
        (VALID_I && s_q.is_comp && !void_now && s_q.dest) |=>
            (FILE_WE_O && FILE_WDATA_O == ~$past(FILE_RDATA_I)))
        else $error("complement to file wrong");
    // write goes back to the register that was read
    chk_comp_waddr: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE4
        (VALID_I && s_q.is_comp && !void_now && s_q.dest) |=>
            (FILE_WADDR_O == $past(FILE_RADDR_O)))
        else $error("complement written to wrong register");
    // complement to working register: no file write
    chk_comp_wreg: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE4
        (VALID_I && s_q.is_comp && !void_now && !s_q.dest) |=>
            (!FILE_WE_O && WREG_O == ~$past(FILE_RDATA_I)))
        else $error("complement to working register wrong");
    // zero flag against the stored result and against the operand
    chk_zero_flag: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE5
        (VALID_I && s_q.is_comp && !void_now) |=>
            (ZERO_O == (($past(s_q.dest) ? FILE_WDATA_O : WREG_O) == 8'h00)
            && ZERO_O == ($past(FILE_RDATA_I) == 8'hFF)))
        else $error("zero flag wrong after complement");
    // complement never skips
    chk_comp_no_skip: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE3
        (VALID_I && s_q.is_comp && !void_now) |=> (!SKIP_O && !NOP_O))
        else $error("complement raised a skip");
    // bit test leaves flags and registers alone
    chk_test_keeps_flag: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE5
        (VALID_I && s_q.is_skip) |=> $stable(ZERO_O) && $stable(WREG_O) && !FILE_WE_O)
        else $error("bit test changed state");
    // discarded word changes nothing
    chk_nop_no_effect: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE2
        NOP_O |-> !FILE_WE_O && !SKIP_O && $stable(WREG_O))
        else $error("discarded word had effect");
    // the word behind a skip is discarded, so no second skip follows
    chk_no_double_skip: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE2
        SKIP_O |=> !SKIP_O)
        else $error("skip twice in a row");
    // stall: no pulse, nothing moves
    chk_stall_no_effect: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE2
        !VALID_I |=> (!FILE_WE_O && !SKIP_O && !NOP_O
            && $stable(WREG_O) && $stable(ZERO_O)))
        else $error("stalled pipeline had effect");
    // opcodes outside the two decoded here have no effect
    chk_other_quiet: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE3
        (VALID_I && !void_now && !s_q.is_skip && !s_q.is_comp) |=> (!FILE_WE_O && !SKIP_O && !NOP_O
            && $stable(WREG_O) && $stable(ZERO_O)))
        else $error("unknown opcode had effect");
endmodule : btsc_exec

// ### tb/btsc_file_model.sv
// ------------------------------------------------------------
// file register array seen from the core
// ------------------------------------------------------------
module btsc_file_model
    import btsc_pkg::*;
(
    input  wire logic                         clk_i,   // core clock
    input  wire logic [btsc_pkg::ADDR_W-1:0]  raddr_i, // read address
    input  wire logic                         we_i,    // write strobe
    input  wire logic [btsc_pkg::ADDR_W-1:0]  waddr_i, // write address
    input  wire logic [btsc_pkg::DATA_W-1:0]  wdata_i, // write data
    output logic      [btsc_pkg::DATA_W-1:0]  rdata_o  // read data, same cycle
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DATA_W-1:0] mem [32]; // loaded by the bench at time zero
    // read is combinational, so a write shows only a cycle later
    assign rdata_o = mem[raddr_i];
    // write on the strobed edge
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end
endmodule : btsc_file_model

// ### tb/btsc_exec_test.sv
module btsc_exec_test;
    timeunit 1ns;
    timeprecision 1ns;
    import btsc_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk = 1'b0;     // core clock
    logic        rst = 1'b1;     // reset, high
    logic        vld = 1'b0;     // word valid
    logic [11:0] instr = 12'h000; // fetched word
    logic [7:0]  rdata, wdata, wreg, sh [32]; // sh: bench copy of the file
    logic [4:0]  raddr, waddr;
    logic        we, zero, skip, no_operation;
    int          err_count = 0;
    int          checks_done = 0;
    always #4 clk = ~clk;
    btsc_exec i_dut (.CLK_I(clk), .RST_I(rst), .VALID_I(vld), .INSTR_I(instr), .FILE_RDATA_I(rdata),
        .FILE_RADDR_O(raddr), .FILE_WE_O(we), .FILE_WADDR_O(waddr), .FILE_WDATA_O(wdata),
        .WREG_O(wreg), .ZERO_O(zero), .SKIP_O(skip), .NOP_O(no_operation));
    btsc_file_model i_file (.clk_i(clk), .raddr_i(raddr), .we_i(we), .waddr_i(waddr), .wdata_i(wdata),
        .rdata_o(rdata));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one word per cycle, driven at the falling edge
    task automatic step(input logic [11:0] w);
        vld = 1'b1;
        instr = w;
        @(negedge clk);
    endtask : step
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // every bit of a mixed word; the voided word is a file write
    task automatic test_skip;
        logic s, z;
        for (int b = 0; b < 8; b++) begin
            s = sh[3][b];
            z = zero;
            step({4'h7, 3'(b), 5'h03});
            step({OPC_COMPLEMENT, 1'b1, 5'h04});
            chk(skip, s);
            chk(zero, z);
            step(12'h000);
            chk(no_operation, s);
            chk(we, !s);
            chk(skip, 1'b0);
        end
        $display("test_skip done");
    endtask : test_skip
    // zero result, same address twice with a 000 word between, both destinations
    task automatic test_complement_file;
        int a;
        logic d;
        logic [7:0] e;
        int adr [4] = '{31, 31, 5, 6};
        for (int i = 0; i < 4; i++) begin
            a = adr[i];
            d = (i != 2);
            e = ~sh[a];
            step({OPC_COMPLEMENT, d, 5'(a)});
            chk(raddr, 8'(a));
            step(12'h000);
            chk(we, d);
            chk(zero, e == 8'h00);
            if (d) begin
                chk(waddr, 8'(a));
                chk(wdata, e);
                sh[a] = e;
            end else begin
                chk(wreg, e);
            end
        end
        $display("test_complement_file done");
    endtask : test_complement_file
    // neighbouring opcodes must do nothing here
    task automatic test_other;
        logic [7:0] w0;
        logic z;
        logic [11:0] ws [3] = '{12'h4A3, 12'h6E3, 12'h2E3};
        for (int i = 0; i < 3; i++) begin
            w0 = wreg;
            z = zero;
            step(ws[i]);
            step(12'h000);
            chk(skip, 1'b0);
            chk(we, 1'b0);
            chk(wreg, w0);
            chk(zero, z);
        end
        $display("test_other done");
    endtask : test_other
    // a taken skip across a stall still discards the next word
    task automatic test_stall;
        step({OPC_BIT_SKIP, 3'h1, 5'h03});
        step({OPC_COMPLEMENT, 1'b1, 5'h04});
        chk(skip, sh[3][1]);
        vld = 1'b0;
        repeat (2) @(negedge clk);
        chk(skip, 1'b0);
        chk(no_operation, 1'b0);
        step(12'h000);
        chk(no_operation, 1'b1);
        chk(we, 1'b0);
        $display("test_stall done");
    endtask : test_stall
    // reset in mid-run drops a pending discard and clears the working register, zero flag and write strobe
    task automatic test_reset;
        step({OPC_BIT_SKIP, 3'h1, 5'h03});
        step(12'h000);
        chk(skip, 1'b1);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk(wreg, W_RESET);
        chk(zero, ZERO_RESET);
        chk(we, 1'b0);
        step({OPC_COMPLEMENT, 1'b0, 5'h05});
        chk(no_operation, 1'b0);
        step(12'h000);
        chk(no_operation, 1'b0);
        chk(wreg, ~sh[5]);
        $display("test_reset done");
    endtask : test_reset
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 32; i++) begin
            sh[i] = (i == 31) ? 8'hFF : 8'(i * 29 + 7);
            i_file.mem[i] = sh[i];
        end
        repeat (20) @(negedge clk);
        rst = 1'b0;
        chk(wreg, W_RESET);
        chk(zero, ZERO_RESET);
        test_complement_file();
        test_skip();
        test_other();
        test_stall();
        test_reset();
        conclude();
    end
    initial begin
        #100000;
        err_count++;
        conclude();
    end
endmodule : btsc_exec_test
